// ---- design/bce_pkg.sv ----
// package of offsets, field positions, polynomials and widths
// assumes an 8-bit register port and a byte-wide flash read port
package bce_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam int unsigned  REG_AW        = 8;
    localparam logic [7:0]   OFF_CTRL      = 8'hce;
    localparam logic [7:0]   OFF_INPUT     = 8'hdd;
    localparam logic [7:0]   OFF_DATA      = 8'hde;
    localparam logic [7:0]   OFF_AUTO      = 8'hd2;
    localparam logic [7:0]   OFF_COUNT     = 8'hd3;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned  CTRL_SEL_BIT  = 4;
    localparam int unsigned  CTRL_INIT_BIT = 3;
    localparam int unsigned  CTRL_VAL_BIT  = 2;
    localparam int unsigned  CTRL_PTR_LSB  = 0;
    localparam int unsigned  PTR_W         = 2;
    localparam int unsigned  AUTO_EN_BIT   = 7;
    localparam int unsigned  PAGE_W        = 6;
    localparam int unsigned  CNT_W         = 8;
    // ------------------------------------------------------------
    // crc constants
    // ------------------------------------------------------------
    localparam int unsigned  BYTE_BITS     = 8;
    localparam logic [15:0]  POLY16        = 16'h1021;
    localparam logic [31:0]  POLY32_NORMAL = 32'h04c11db7;
    localparam logic [31:0]  POLY32_REFL   = 32'hedb88320;
    localparam logic [31:0]  START_ZERO    = 32'h00000000;
    localparam logic [31:0]  START_ONES    = 32'hffffffff;
    localparam int unsigned  SECTOR_LOG2   = 9;
    localparam logic [7:0]   RESET_BYTE    = 8'h00;
    // ------------------------------------------------------------
    // known single-byte vectors from an all-ones start
    // ------------------------------------------------------------
    localparam logic [7:0]   VEC_IN        = 8'h63;
    localparam logic [15:0]  VEC_OUT16     = 16'hbd35;
    localparam logic [31:0]  VEC_OUT32     = 32'hf9462090;
endpackage : bce_pkg

// ---- design/bce_byte_step.sv ----
// folds one input byte into the running crc, combinational
// assumes the caller registers the result
`timescale 1ns/100ps
module bce_byte_step
    import bce_pkg::*;
(
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        width16,
    output logic      [31:0] crc_out
);
    logic [15:0] acc16;
    logic [31:0] acc32;

    always_comb begin
        acc16 = crc_in[15:0] ^ {data_in, RESET_BYTE};
        acc32 = crc_in ^ {24'h000000, data_in};
        for (int i = 0; i < BYTE_BITS; i++) begin
            if (acc16[15]) begin
                acc16 = {acc16[14:0], 1'b0} ^ POLY16;
            end else begin
                acc16 = {acc16[14:0], 1'b0};
            end
            if (acc32[0]) begin
                acc32 = {1'b0, acc32[31:1]} ^ POLY32_REFL;
            end else begin
                acc32 = {1'b0, acc32[31:1]};
            end
        end
        crc_out = width16 ? {crc_in[31:16], acc16} : acc32;
    end
endmodule : bce_byte_step

// ---- design/bce_flash_walker.sv ----
// walks flash sectors in ascending order, one byte read per cycle
// assumes flash returns read data in the cycle after flash_rd
`timescale 1ns/100ps
module bce_flash_walker
    import bce_pkg::*;
#(
    parameter int unsigned FLASH_AW = 16
)
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                start,
    input  wire logic [PAGE_W-1:0]   start_page,
    input  wire logic [CNT_W-1:0]    sector_count,
    output logic                     busy,
    output logic                     flash_rd,
    output logic      [FLASH_AW-1:0] flash_addr
);
    localparam int unsigned LEFT_W = CNT_W + SECTOR_LOG2;

    if (FLASH_AW < PAGE_W + SECTOR_LOG2) begin : g_bad_aw
        $error("FLASH_AW too small for page index");
    end

    logic [FLASH_AW-1:0] cur;
    logic [LEFT_W-1:0]   left;
    wire  [FLASH_AW-1:0] base = FLASH_AW'({start_page, {SECTOR_LOG2{1'b0}}});
    wire  [LEFT_W-1:0]   total = {sector_count, {SECTOR_LOG2{1'b0}}};
    wire                 last = (left == LEFT_W'(1));

    always_ff @(posedge clk) begin
        if (srst) begin
            busy       <= 1'b0;
            flash_rd   <= 1'b0;
            flash_addr <= '0;
            cur        <= '0;
            left       <= '0;
        end else if (start && !busy) begin
            busy       <= (sector_count != '0);
            flash_rd   <= 1'b0;
            cur        <= base;
            left       <= total;
        end else if (busy) begin
            flash_rd   <= 1'b1;
            flash_addr <= cur;
            cur        <= cur + FLASH_AW'(1);
            left       <= left - LEFT_W'(1);
            busy       <= !last;
        end else begin
            flash_rd   <= 1'b0;
        end
    end
endmodule : bce_flash_walker

// ---- design/bce_top.sv ----
// crc engine top: register port, result store, auto flash mode
// assumes a single master on the register port and a stalled cpu
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps

// How it works
// - 16-bit mode uses poly 0x1021, msb first
// - 16-bit: byte xored into upper result byte
// - 16-bit: eight left shifts with conditional poly
// - 32-bit mode uses reflected 0x04C11DB7 polynomial
// - 32-bit: byte xored into lowest result byte
// - 32-bit: eight right shifts, xor 0xEDB88320
// - start value is all zeros or ones
// - width select clear 32-bit, set 16-bit
// - value select clear zeros, set ones
// - each input byte write folds into result
// - sector count register, 512 bytes per sector
// - control write with auto enabled starts walk
// - cpu stalled while flash walk runs
// - result width 32 or 16 bits by select
// - pointer selects result byte, advances per access
// - result holds until init, overwrite, input, or flash fetch fold
// - pointer byte map; 16-bit aliases upper codes
module bce_top
    import bce_pkg::*;
#(
    parameter int unsigned FLASH_AW = 16
)
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [REG_AW-1:0]   reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    output logic                     flash_rd,
    output logic      [FLASH_AW-1:0] flash_addr,
    input  wire logic [7:0]          flash_rdata,
    output logic                     cpu_stall
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (FLASH_AW < PAGE_W + SECTOR_LOG2) begin : g_bad_aw
        $error("FLASH_AW too small for page index");
    end
    if (PTR_W != 2) begin : g_bad_ptr
        $error("pointer must be two bits for four result bytes");
    end
    if (PAGE_W + 2 > BYTE_BITS) begin : g_bad_page
        $error("auto register cannot hold enable and page index");
    end
    if (CNT_W != BYTE_BITS) begin : g_bad_cnt
        $error("sector count must fill one register byte");
    end

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic [1:0] byte_index(input logic [PTR_W-1:0] p,
                                              input logic w16);
        byte_index = w16 ? {1'b0, p[0]} : p;
    endfunction : byte_index

    function automatic logic [7:0] get_byte(input logic [31:0] v,
                                            input logic [1:0] idx);
        case (idx)
            2'h0:    get_byte = v[7:0];
            2'h1:    get_byte = v[15:8];
            2'h2:    get_byte = v[23:16];
            default: get_byte = v[31:24];
        endcase
    endfunction : get_byte

    function automatic logic [31:0] put_byte(input logic [31:0] v,
                                             input logic [1:0] idx,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = v;
        case (idx)
            2'h0:    r[7:0]   = b;
            2'h1:    r[15:8]  = b;
            2'h2:    r[23:16] = b;
            default: r[31:24] = b;
        endcase
        put_byte = r;
    endfunction : put_byte

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic              poly_width_select;
    logic              init_value_select;
    logic [PTR_W-1:0]  result_byte_pointer;
    logic [7:0]        crc_byte_input;
    logic              auto_flash_enable;
    logic [PAGE_W-1:0] auto_page;
    logic [CNT_W-1:0]  flash_sector_count;
    logic [31:0]       result;
    logic              fetch_pending;
    logic              walk_busy;
    logic [31:0]       step_out;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire        sel_ctrl   = (reg_addr == OFF_CTRL);
    wire        sel_input  = (reg_addr == OFF_INPUT);
    wire        sel_data   = (reg_addr == OFF_DATA);
    wire        sel_auto   = (reg_addr == OFF_AUTO);
    wire        sel_count  = (reg_addr == OFF_COUNT);
    wire        wr_ctrl    = reg_wr && sel_ctrl;
    wire        wr_input   = reg_wr && sel_input;
    wire        wr_data    = reg_wr && sel_data;
    wire        data_acc   = (reg_wr || reg_rd) && sel_data;
    wire        result_init_strobe = wr_ctrl && reg_wdata[CTRL_INIT_BIT];
    wire        auto_start = wr_ctrl && auto_flash_enable;
    wire [1:0]  byte_idx   = byte_index(result_byte_pointer, poly_width_select);
    wire [31:0] start_val  = init_value_select ? START_ONES : START_ZERO;
    wire        next_width = reg_wdata[CTRL_SEL_BIT];
    wire [31:0] next_start = reg_wdata[CTRL_VAL_BIT] ? START_ONES : START_ZERO;
    wire        fold       = fetch_pending || wr_input;
    wire [7:0]  fold_byte  = fetch_pending ? flash_rdata : reg_wdata;
    wire [7:0]  ctrl_view  = {3'h0, poly_width_select, 1'b0, init_value_select,
                              result_byte_pointer};

    logic [7:0]  next_rdata;
    logic [31:0] next_result;

    always_comb begin
        case (1'b1)
            sel_ctrl:  next_rdata = ctrl_view;
            sel_input: next_rdata = crc_byte_input;
            sel_data:  next_rdata = get_byte(result, byte_idx);
            sel_auto:  next_rdata = {auto_flash_enable, 1'b0, auto_page};
            sel_count: next_rdata = flash_sector_count;
            default:   next_rdata = RESET_BYTE;
        endcase
    end

    always_comb begin
        if (result_init_strobe) begin
            next_result = next_start;
        end else if (fold) begin
            next_result = step_out;
        end else if (wr_data) begin
            next_result = put_byte(result, byte_idx, reg_wdata);
        end else begin
            next_result = result;
        end
    end

    // ------------------------------------------------------------
    // datapath and sequencer
    // ------------------------------------------------------------
    bce_byte_step u_step (
        .crc_in  (result),
        .data_in (fold_byte),
        .width16 (poly_width_select),
        .crc_out (step_out)
    );

    bce_flash_walker #(
        .FLASH_AW (FLASH_AW)
    ) u_walk (
        .clk          (clk),
        .srst         (srst),
        .start        (auto_start),
        .start_page   (auto_page),
        .sector_count (flash_sector_count),
        .busy         (walk_busy),
        .flash_rd     (flash_rd),
        .flash_addr   (flash_addr)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            poly_width_select   <= 1'b0;
            init_value_select   <= 1'b0;
            result_byte_pointer <= '0;
        end else if (wr_ctrl) begin
            poly_width_select   <= next_width;
            init_value_select   <= reg_wdata[CTRL_VAL_BIT];
            result_byte_pointer <= reg_wdata[CTRL_PTR_LSB +: PTR_W];
        end else if (data_acc) begin
            result_byte_pointer <= result_byte_pointer + PTR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            crc_byte_input     <= RESET_BYTE;
            auto_flash_enable  <= 1'b0;
            auto_page          <= '0;
            flash_sector_count <= '0;
        end else begin
            if (wr_input) begin
                crc_byte_input <= reg_wdata;
            end
            if (reg_wr && sel_auto) begin
                auto_flash_enable <= reg_wdata[AUTO_EN_BIT];
                auto_page         <= reg_wdata[PAGE_W-1:0];
            end
            if (reg_wr && sel_count) begin
                flash_sector_count <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            result        <= START_ZERO;
            reg_rdata     <= RESET_BYTE;
            fetch_pending <= 1'b0;
            cpu_stall     <= 1'b0;
        end else begin
            result        <= next_result;
            reg_rdata     <= reg_rd ? next_rdata : RESET_BYTE;
            fetch_pending <= flash_rd;
            cpu_stall     <= auto_start || walk_busy || flash_rd;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_init_loads_start: assert property (
        @(posedge clk) disable iff (srst)
        result_init_strobe |=> result == $past(next_start))
        else $error("init did not load start value");

    chk_read_selected_byte: assert property (
        @(posedge clk) disable iff (srst)
        reg_rd && sel_data |=> reg_rdata == get_byte($past(result), $past(byte_idx)))
        else $error("result byte read mismatch");

    chk_ptr_advances: assert property (
        @(posedge clk) disable iff (srst)
        data_acc |=> result_byte_pointer == $past(result_byte_pointer) + PTR_W'(1))
        else $error("pointer did not advance");

    chk_result_holds: assert property (
        @(posedge clk) disable iff (srst)
        !result_init_strobe && !fold && !wr_data |=> $stable(result))
        else $error("result changed without cause");

    chk_vec_crc16: assert property (
        @(posedge clk) disable iff (srst)
        wr_input && poly_width_select && result[15:0] == START_ONES[15:0]
            && reg_wdata == VEC_IN |=> result[15:0] == VEC_OUT16)
        else $error("16-bit crc vector wrong");

    chk_vec_crc32: assert property (
        @(posedge clk) disable iff (srst)
        wr_input && !poly_width_select && result == START_ONES
            && reg_wdata == VEC_IN |=> result == VEC_OUT32)
        else $error("32-bit crc vector wrong");

    chk_stall_covers_fetch: assert property (
        @(posedge clk) disable iff (srst)
        flash_rd |-> cpu_stall ##1 cpu_stall)
        else $error("fetch without stall");

    chk_walk_first_addr: assert property (
        @(posedge clk) disable iff (srst)
        auto_start && !walk_busy && flash_sector_count != '0
            |-> ##2 flash_rd && flash_addr == FLASH_AW'({$past(auto_page, 2),
                                                         {SECTOR_LOG2{1'b0}}}))
        else $error("walk did not start at page base");

    chk_zero_count_quick: assert property (
        @(posedge clk) disable iff (srst)
        auto_start && !walk_busy && flash_sector_count == '0
            |=> cpu_stall ##1 !cpu_stall)
        else $error("empty walk stall length wrong");

    chk_ctrl_unused_zero: assert property (
        @(posedge clk) disable iff (srst)
        reg_rd && sel_ctrl |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[CTRL_INIT_BIT])
        else $error("control unused bits not zero");

    // ------------------------------------------------------------
    // field, result and walk checks
    // ------------------------------------------------------------
    chk_init_matches_select: assert property (
        @(posedge clk) disable iff (srst)
        result_init_strobe |=> result == start_val)
        else $error("init value differs from selected start");

    chk_width_from_write: assert property (
        @(posedge clk) disable iff (srst)
        wr_ctrl |=> poly_width_select == $past(reg_wdata[CTRL_SEL_BIT]))
        else $error("width select not taken from write");

    chk_value_from_write: assert property (
        @(posedge clk) disable iff (srst)
        wr_ctrl |=> init_value_select == $past(reg_wdata[CTRL_VAL_BIT]))
        else $error("start value select not taken from write");

    chk_ptr_from_write: assert property (
        @(posedge clk) disable iff (srst)
        wr_ctrl |=> result_byte_pointer == $past(reg_wdata[CTRL_PTR_LSB +: PTR_W]))
        else $error("pointer not loaded from control write");

    chk_input_readback: assert property (
        @(posedge clk) disable iff (srst)
        wr_input |=> crc_byte_input == $past(reg_wdata))
        else $error("input byte not kept");

    chk_upper_half_kept: assert property (
        @(posedge clk) disable iff (srst)
        fold && poly_width_select && !result_init_strobe
            |=> result[31:16] == $past(result[31:16]))
        else $error("16-bit fold touched upper half");

    chk_data_write_lands: assert property (
        @(posedge clk) disable iff (srst)
        wr_data && !fold && !result_init_strobe
            |=> get_byte(result, $past(byte_idx)) == $past(reg_wdata))
        else $error("result byte write lost");

    chk_rdata_idle_zero: assert property (
        @(posedge clk) disable iff (srst)
        !reg_rd |=> reg_rdata == RESET_BYTE)
        else $error("read data not zero outside read");

    chk_stall_while_busy: assert property (
        @(posedge clk) disable iff (srst)
        walk_busy |-> cpu_stall)
        else $error("walk busy without stall");

    chk_idle_no_fetch: assert property (
        @(posedge clk) disable iff (srst)
        !cpu_stall |-> !flash_rd)
        else $error("fetch while cpu runs");

    chk_walk_addr_step: assert property (
        @(posedge clk) disable iff (srst)
        flash_rd && $past(flash_rd) |-> flash_addr == $past(flash_addr) + FLASH_AW'(1))
        else $error("walk address not ascending by one");
endmodule : bce_top

// ---- dv/bce_flash_model.sv ----
// flash model for the auto walk: one byte per read request
// assumes read data due in the cycle after flash_rd
`timescale 1ns/100ps
module bce_flash_model #(
    parameter int unsigned FLASH_AW = 16
)
(
    input  wire logic                clk,
    input  wire logic                flash_rd,
    input  wire logic [FLASH_AW-1:0] flash_addr,
    output logic      [7:0]          flash_rdata
);
    // ------------------------------------------------------------
    // byte pattern and read answer
    // ------------------------------------------------------------
    function automatic logic [7:0] pattern(input logic [FLASH_AW-1:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pattern

    logic [7:0] rdata_q = 8'h00;

    assign flash_rdata = rdata_q;

    // answers one cycle after each request, toggles when idle
    always @(posedge clk) begin
        if (flash_rd)
            rdata_q <= pattern(flash_addr);
        else
            rdata_q <= ~rdata_q;
    end
endmodule : bce_flash_model

// ---- dv/bce_top_test.sv ----
// self-checking bench for the crc engine top
// assumes one register master and the flash model on the far side
`timescale 1ns/100ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module bce_top_test;
    import bce_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        flash_rd;
    logic [15:0] flash_addr;
    logic [7:0]  flash_rdata;
    logic        cpu_stall;
    int          mismatches = 0;
    int          n_tests = 0;
    int          n_rd = 0;
    logic [15:0] exp_addr = 16'h0400;

    always #5 clk = ~clk;

    bce_top #(.FLASH_AW(16)) u_bce_top (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .cpu_stall(cpu_stall)
    );
    bce_flash_model #(.FLASH_AW(16)) u_bce_flash_model (
        .clk(clk), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata)
    );
    // ------------------------------------------------------------
    // reference crc and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] crc32(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
        return c;
    endfunction : crc32

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic check_result(input logic [31:0] r, input logic w16);
        logic [7:0] d;
        int         idx;
        for (int k = 0; k < 4; k++) begin
            rd(OFF_DATA, d);
            idx = w16 ? k % 2 : k;
            `CHK(d, r[8*idx +: 8], "result byte")
        end
    endtask : check_result

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // flash walk monitor and watchdog
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (flash_rd === 1'b1) begin
            `CHK(flash_addr, exp_addr, "flash address")
            `CHK(cpu_stall, 1'b1, "stall during walk")
            exp_addr = exp_addr + 16'h0001;
            n_rd++;
        end
    end

    initial begin
        #(5000 * 10);
        mismatches++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        print_verdict();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        logic [39:0] vec [3] = '{40'h63, 40'haabbcc, 40'h0000aabbcc};
        int          len [3] = '{1, 3, 5};
        logic [15:0] o16 [3] = '{16'hbd35, 16'h6cf6, 16'hb166};
        logic [31:0] o32 [3] = '{32'hf9462090, 32'h41b207b3, 32'h78d129bc};
        logic [31:0] r;
        logic [7:0]  d;
        int          cyc;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_CTRL, d);
        `CHK(d, 8'h00, "ctrl reset")
        check_result(32'h0, 1'b0);
        // control readback: init reads 0, pointer loaded
        wr(OFF_CTRL, 8'h1f);
        rd(OFF_CTRL, d);
        `CHK(d, 8'h17, "ctrl readback")
        // documented vectors in both widths from all ones
        for (int w = 0; w < 2; w++) begin
            for (int v = 0; v < 3; v++) begin
                wr(OFF_CTRL, w ? 8'h1c : 8'h0c);
                for (int i = len[v] - 1; i >= 0; i--)
                    wr(OFF_INPUT, vec[v][8*i +: 8]);
                r = w ? {16'h0, o16[v]} : o32[v];
                check_result(r, w[0]);
            end
        end
        // zero start, both widths
        wr(OFF_CTRL, 8'h08);
        check_result(32'h0, 1'b0);
        wr(OFF_CTRL, 8'h1c);
        wr(OFF_CTRL, 8'h18);
        check_result(32'h0, 1'b1);
        // overwrite through result port, hold, then fold
        wr(OFF_CTRL, 8'h00);
        for (int k = 0; k < 4; k++)
            wr(OFF_DATA, 8'h11 * (k + 1));
        wr(8'h10, 8'hff);
        rd(8'h10, d);
        `CHK(d, 8'h00, "unmapped read")
        check_result(32'h44332211, 1'b0);
        wr(OFF_INPUT, 8'h63);
        rd(OFF_INPUT, d);
        `CHK(d, 8'h63, "input readback")
        check_result(crc32(32'h44332211, 8'h63), 1'b0);
        // empty walk, then one sector from page 2
        wr(OFF_CTRL, 8'h0c);
        wr(OFF_AUTO, 8'h02);
        wr(OFF_AUTO, 8'h82);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_CTRL, 8'h04);
        #1 `CHK(cpu_stall, 1'b1, "empty walk stall")
        @(posedge clk);
        #1 `CHK(cpu_stall, 1'b0, "empty walk end")
        wr(OFF_COUNT, 8'h01);
        wr(OFF_CTRL, 8'h04);
        cyc = 0;
        while (cyc < 600) begin
            @(posedge clk);
            #1 cyc++;
            if (cpu_stall === 1'b0)
                break;
        end
        `CHK(cyc, 514, "stall length")
        `CHK(n_rd, 512, "sector length")
        wr(OFF_AUTO, 8'h02);
        r = 32'hffffffff;
        for (int i = 0; i < 512; i++) begin
            d = 8'h04 ^ (i >> 8) ^ i[7:0] ^ 8'h5a;
            r = crc32(r, d);
        end
        check_result(r, 1'b0);
        print_verdict();
    end
endmodule : bce_top_test
